// ==== hw/byte_fifo.sv ====
/*
 Synchronous FIFO with registered full and empty indications.
 Assumes one clock and a synchronous active-high reset; depth a power of two.
*/
`default_nettype none
module byte_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic sys_rst,
	byte_stream_if.sink push,
	byte_stream_if.source pop
);
	localparam int AW = $clog2(DEPTH);

	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
			$error("byte_fifo depth must be a power of two, at least 2");
		end
	endgenerate

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] cnt;
		logic in_ready;
		logic out_valid;
	} fifo_state_t;

	fifo_state_t r;
	fifo_state_t next_r;
	logic do_push;
	logic do_pop;

	// Flags are registered so the top can hand ready straight out
	assign push.ready = r.in_ready;
	assign pop.valid = r.out_valid;
	assign pop.data = r.mem[r.rd];

	// Pointer and count update; push and pop may coincide
	always_comb begin
		next_r = r;
		do_push = push.valid && r.in_ready;
		do_pop = pop.ready && r.out_valid;
		if (do_push) begin
			next_r.mem[r.wr] = push.data;
			next_r.wr = r.wr + 1'b1;
		end
		if (do_pop) begin
			next_r.rd = r.rd + 1'b1;
		end
		next_r.cnt = r.cnt + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
		next_r.in_ready = (next_r.cnt != (AW+1)'(DEPTH));
		next_r.out_valid = (next_r.cnt != '0);
		if (sys_rst) begin
			next_r = '0;
			next_r.in_ready = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		r <= next_r;
	end
endmodule // byte_fifo
`default_nettype wire

// ==== hw/byte_stream_if.sv ====
/*
 Valid/ready stream carrier between the sequencer and its FIFO.
 Assumes both ends run on the same clock.
*/
`default_nettype none
interface byte_stream_if #(parameter int W = 8);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport source (output valid, output data, input ready);
	modport sink (input valid, input data, output ready);
endinterface
`default_nettype wire

// ==== hw/epp_cycle_sequencer.sv ====
/*
 EPP address/data cycle sequencer (1.9 and 1.7 handshakes) with a DMA-fed
 forward FIFO mode. Assumes ISA strobes, select and data arrive from pins,
 while mode, variant, direction bit and timeout clear come from logic on clk.
*/
`default_nettype none
// Functional notes
// - Peripheral wait counts only after holding one level for 50 ns.
// - Write indication stays high except during an EPP write cycle.
// - In 1.9 reads, release port data before asserting the strobe.
// - In 1.9, assert strobe only once peripheral wait is asserted.
// - In 1.9, drop strobe only after peripheral wait deasserts.
// - Read data reaches the system bus before the host stretch ends.
// - Stretch host cycle on EPP strobe until peripheral wait deasserts.
// - In 1.7 writes, strobe ends with the host write strobe.
// - In 1.7 reads, strobe ends with host read, then data released; the code drops strobe and releases data in the same cycle.
// - Mode 101 moves DMA bytes forward to the peripheral.
// - FIFO mode ignores acknowledge; paces bytes on busy only.
// - FIFO mode holds data past strobe until busy low and hold elapsed.
module epp_cycle_sequencer (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [2:0] mode,
	input wire logic epp_variant_17,
	input wire logic port_direction_bit,
	input wire logic timeout_clear,
	input wire logic host_ior_n,
	input wire logic host_iow_n,
	input wire logic host_epp_sel,
	input wire logic host_addr_cycle,
	input wire logic [7:0] system_data_bus_in,
	output logic [7:0] system_data_bus_out,
	output logic system_data_bus_oe,
	output logic iochrdy_stretch,
	output logic timeout_flag,
	input wire logic dma_valid,
	input wire logic [7:0] dma_data,
	output logic dma_ready,
	input wire logic wait_n,
	input wire logic busy,
	output logic write_n,
	output logic data_strobe_n,
	output logic addr_strobe_n,
	output logic strobe_n,
	input wire logic [7:0] port_data_lines_in,
	output logic [7:0] port_data_lines_out,
	output logic port_data_lines_oe_n
);
	typedef enum logic [6:0] {
		S_IDLE = 7'h01,
		S_SETUP = 7'h02,
		S_STROBE = 7'h04,
		S_DONE = 7'h08,
		S_FINISH = 7'h10,
		S_F_SETUP = 7'h20,
		S_F_PULSE = 7'h40
	} seq_state_t;

	typedef struct packed {
		seq_state_t st;
		logic f_hold;
		logic [1:0] ior_s;
		logic [1:0] iow_s;
		logic [1:0] sel_s;
		logic [1:0] adr_s;
		logic [1:0] wait_s;
		logic [1:0] busy_s;
		logic [7:0] wd_s0;
		logic [7:0] wd_s1;
		logic [7:0] pd_s0;
		logic [7:0] pd_s1;
		logic wait_last;
		logic wait_f;
		logic [epp_pkg::CNT_W-1:0] settle;
		logic [epp_pkg::TMO_W-1:0] tmo;
		logic [epp_pkg::CNT_W-1:0] cnt;
		logic is_read;
		logic is_addr;
		logic pop;
		logic [7:0] sd_out;
		logic sd_oe;
		logic stretch;
		logic tmo_flag;
		logic write_n;
		logic dstb_n;
		logic astb_n;
		logic strobe_n;
		logic [7:0] pd_out;
		logic pd_oe_n;
	} seq_reg_t;

	seq_reg_t r;
	seq_reg_t next_r;
	logic host_active;
	logic host_idle;
	logic epp_mode;

	byte_stream_if #(.W(epp_pkg::DATA_W)) in_if ();
	byte_stream_if #(.W(epp_pkg::DATA_W)) out_if ();

	// DMA bytes enter the FIFO; its ready throttles the DMA side
	assign in_if.valid = dma_valid;
	assign in_if.data = dma_data;
	assign dma_ready = in_if.ready;
	assign out_if.ready = r.pop;

	byte_fifo #(
		.W(epp_pkg::DATA_W),
		.DEPTH(epp_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.sys_rst(sys_rst),
		.push(in_if),
		.pop(out_if)
	);

	// Outputs come straight from the state register
	assign system_data_bus_out = r.sd_out;
	assign system_data_bus_oe = r.sd_oe;
	assign iochrdy_stretch = r.stretch;
	assign timeout_flag = r.tmo_flag;
	assign write_n = r.write_n;
	assign data_strobe_n = r.dstb_n;
	assign addr_strobe_n = r.astb_n;
	assign strobe_n = r.strobe_n;
	assign port_data_lines_out = r.pd_out;
	assign port_data_lines_oe_n = r.pd_oe_n;

	// Next-state logic for the whole sequencer
	always_comb begin
		next_r = r;
		// Two-stage synchronisers; only stage 1 is read below
		next_r.ior_s = {r.ior_s[0], host_ior_n};
		next_r.iow_s = {r.iow_s[0], host_iow_n};
		next_r.sel_s = {r.sel_s[0], host_epp_sel};
		next_r.adr_s = {r.adr_s[0], host_addr_cycle};
		next_r.wait_s = {r.wait_s[0], wait_n};
		next_r.busy_s = {r.busy_s[0], busy};
		next_r.wd_s0 = system_data_bus_in;
		next_r.wd_s1 = r.wd_s0;
		next_r.pd_s0 = port_data_lines_in;
		next_r.pd_s1 = r.pd_s0;
		next_r.pop = 1'b0;
		epp_mode = (mode != epp_pkg::MODE_FIFO);
		host_active = r.sel_s[1] && (!r.ior_s[1] || !r.iow_s[1]);
		host_idle = r.ior_s[1] && r.iow_s[1];

		// Cable ringing filter: any transition restarts the count
		if (r.wait_s[1] != r.wait_last) begin
			next_r.wait_last = r.wait_s[1];
			next_r.settle = '0;
		end else if (r.settle != epp_pkg::CNT_W'(epp_pkg::WAIT_SETTLE_CYC)) begin
			next_r.settle = r.settle + 1'b1;
		end else begin
			next_r.wait_f = r.wait_last;
		end

		// Handshake watchdog runs only while a host cycle is open
		if (r.st == S_SETUP || r.st == S_STROBE) begin
			next_r.tmo = r.tmo + 1'b1;
		end else begin
			next_r.tmo = '0;
		end
		if (timeout_clear) begin
			next_r.tmo_flag = 1'b0;
		end

		case (r.st)
			S_IDLE: begin
				if (epp_mode && host_active) begin
					next_r.is_read = !r.ior_s[1];
					next_r.is_addr = r.adr_s[1];
					next_r.stretch = 1'b1;
					if (!r.ior_s[1]) begin
						next_r.pd_oe_n = 1'b1;
						next_r.write_n = 1'b1;
					end else begin
						next_r.pd_out = r.wd_s1;
						next_r.pd_oe_n = 1'b0;
						// 1.7 takes the write level from software's direction bit
						next_r.write_n = epp_variant_17 ? port_direction_bit : 1'b0;
					end
					next_r.st = S_SETUP;
				end else if (!epp_mode && !r.f_hold && out_if.valid && !r.busy_s[1]) begin
					next_r.pd_out = out_if.data;
					next_r.pd_oe_n = 1'b0;
					next_r.pop = 1'b1;
					next_r.cnt = '0;
					next_r.st = S_F_SETUP;
				end else if (!epp_mode && r.f_hold) begin
					// Data stays on the lines indefinitely when nothing waits
					next_r.cnt = (r.cnt == '1) ? r.cnt : r.cnt + 1'b1;
					if (!r.busy_s[1] &&
						r.cnt >= epp_pkg::CNT_W'(epp_pkg::FIFO_HOLD_CYC)) begin
						next_r.f_hold = 1'b0;
					end
				end else if (epp_mode) begin
					next_r.f_hold = 1'b0;
				end
			end
			S_SETUP: begin
				// 1.9 waits for the peripheral; 1.7 strobes at once
				if (epp_variant_17 || !r.wait_f) begin
					next_r.dstb_n = r.is_addr;
					next_r.astb_n = !r.is_addr;
					next_r.cnt = '0;
					next_r.st = S_STROBE;
				end
			end
			S_STROBE: begin
				if (!epp_variant_17 && r.wait_f) begin
					next_r.dstb_n = 1'b1;
					next_r.astb_n = 1'b1;
					next_r.sd_out = r.pd_s1;
					next_r.sd_oe = r.is_read;
					next_r.st = S_DONE;
				end else if (epp_variant_17) begin
					// No handshake gates 1.7, so give data and wait time to cross the syncs
					next_r.cnt = (r.cnt == '1) ? r.cnt : r.cnt + 1'b1;
					if (r.wait_f && r.stretch &&
						r.cnt >= epp_pkg::CNT_W'(epp_pkg::SAMPLE_LAT_CYC)) begin
						next_r.sd_out = r.pd_s1;
						next_r.sd_oe = r.is_read;
						next_r.st = S_DONE;
					end
				end
			end
			S_DONE: begin
				// Stretch drops one cycle after the read data is on the bus
				next_r.stretch = 1'b0;
				next_r.st = S_FINISH;
			end
			S_FINISH: begin
				if (host_idle) begin
					next_r.dstb_n = 1'b1;
					next_r.astb_n = 1'b1;
					next_r.write_n = 1'b1;
					next_r.sd_oe = 1'b0;
					next_r.pd_oe_n = 1'b1;
					next_r.st = S_IDLE;
				end
			end
			S_F_SETUP: begin
				next_r.cnt = r.cnt + 1'b1;
				if (r.cnt >= epp_pkg::CNT_W'(epp_pkg::FIFO_SETUP_CYC - 1)) begin
					next_r.strobe_n = 1'b0;
					next_r.cnt = '0;
					next_r.st = S_F_PULSE;
				end
			end
			S_F_PULSE: begin
				// Acknowledge is never looked at; busy alone paces bytes
				next_r.cnt = r.cnt + 1'b1;
				if (r.cnt >= epp_pkg::CNT_W'(epp_pkg::FIFO_PULSE_CYC - 1)) begin
					next_r.strobe_n = 1'b1;
					next_r.cnt = '0;
					next_r.f_hold = 1'b1;
					next_r.st = S_IDLE;
				end
			end
			default: begin
				next_r.st = S_IDLE;
			end
		endcase

		// Abort wins over the state step; set wins over clear
		if ((r.st == S_SETUP || r.st == S_STROBE) &&
			r.tmo >= epp_pkg::TMO_W'(epp_pkg::TIMEOUT_CYC - 1)) begin
			next_r.dstb_n = 1'b1;
			next_r.astb_n = 1'b1;
			next_r.stretch = 1'b0;
			next_r.tmo_flag = 1'b1;
			next_r.st = S_FINISH;
		end

		if (sys_rst) begin
			next_r = '0;
			next_r.st = S_IDLE;
			next_r.ior_s = 2'h3;
			next_r.iow_s = 2'h3;
			next_r.wait_s = 2'h3;
			next_r.wait_last = 1'b1;
			next_r.wait_f = 1'b1;
			next_r.write_n = 1'b1;
			next_r.dstb_n = 1'b1;
			next_r.astb_n = 1'b1;
			next_r.strobe_n = 1'b1;
			next_r.pd_out = epp_pkg::RESET_DATA;
			next_r.pd_oe_n = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		r <= next_r;
	end
endmodule // epp_cycle_sequencer
`default_nettype wire

// ==== hw/epp_pkg.sv ====
/*
 Shared constants for the EPP cycle sequencer and its byte FIFO.
 Assumes a single 10 MHz system clock; all times are converted to cycles here.
*/
`default_nettype none
package epp_pkg;
	localparam int CLK_NS = 100;
	// Peripheral wait must hold still this long before it counts
	localparam int WAIT_SETTLE_NS = 50;
	localparam int WAIT_SETTLE_CYC = (WAIT_SETTLE_NS + CLK_NS - 1) / CLK_NS;
	// Strobe-low cycles before 1.7 may sample: two sync stages plus the filter
	localparam int SAMPLE_LAT_CYC = WAIT_SETTLE_CYC + 3;
	// Handshake abort window, lower edge of the allowed range
	localparam int TIMEOUT_NS = 10000;
	localparam int TIMEOUT_CYC = (TIMEOUT_NS + CLK_NS - 1) / CLK_NS;
	// FIFO mode strobe timing
	localparam int FIFO_SETUP_NS = 600;
	localparam int FIFO_SETUP_CYC = (FIFO_SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int FIFO_PULSE_NS = 600;
	localparam int FIFO_PULSE_CYC = (FIFO_PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int FIFO_HOLD_NS = 450;
	localparam int FIFO_HOLD_CYC = (FIFO_HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [2:0] MODE_FIFO = 3'h5;
	localparam int FIFO_DEPTH = 16;
	localparam int DATA_W = 8;
	localparam int TMO_W = 8;
	localparam int CNT_W = 4;
	localparam logic [7:0] RESET_DATA = 8'h00;
endpackage
`default_nettype wire

// ==== tb/epp_cycle_sequencer_bench.sv ====
/*
 Self-checking bench: EPP host cycles, timeout, FIFO fill and drain.
 Assumes the peripheral model and the bound checker.
*/
`default_nettype none
module epp_cycle_sequencer_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, sys_rst = 1'b1, epp_variant_17 = 1'b0, port_direction_bit = 1'b0;
	logic timeout_clear = 1'b0, host_ior_n = 1'b1, host_iow_n = 1'b1, host_epp_sel = 1'b0;
	logic host_addr_cycle = 1'b0, dma_valid = 1'b0, stall = 1'b0, fstall = 1'b0;
	logic [2:0] mode = 3'h0;
	logic [7:0] system_data_bus_in = 8'h00, dma_data = 8'h00, rd_val = 8'h00, r;
	logic wait_n, busy, write_n, data_strobe_n, addr_strobe_n, strobe_n, dma_ready;
	logic system_data_bus_oe, iochrdy_stretch, timeout_flag, port_data_lines_oe_n;
	logic [7:0] port_data_lines_in, port_data_lines_out, system_data_bus_out;
	logic [31:0] seed = 32'h0000005a;
	logic [7:0] q[$];
	logic [7:0] got[$];
	int n_mismatch = 0, check_count = 0, i;
	epp_cycle_sequencer u_epp_cycle_sequencer (.*);
	epp_peripheral_model u_epp_peripheral_model (.*);
	initial begin
		forever #50 clk = ~clk;
	end
	// Byte the peripheral takes at each FIFO strobe
	always @(negedge strobe_n) begin
		if (mode == epp_pkg::MODE_FIFO) begin
			got.push_back(port_data_lines_out);
		end
	end
	function automatic logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction
	task automatic tick();
		@(posedge clk);
		#2;
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		check_count++;
		if (s !== e) begin
			n_mismatch++;
			$display("Error %0t: saw %h expected %h", $time, s, e);
		end
	endtask
	task automatic hang(input int k, input int lim);
		if (k == lim) begin
			n_mismatch++;
			finish_test();
		end
	endtask
	// One host cycle, strobe held until the stretch is gone after the command
	task automatic cyc(input logic wr, input logic ad, input logic tmo);
		int k;
		logic hit, w;
		logic [7:0] d, pd;
		hit = 1'b0;
		w = 1'b1;
		pd = 8'h00;
		d = rnd();
		port_direction_bit = epp_variant_17 & !wr;
		rd_val = d;
		system_data_bus_in = d;
		tick();
		host_addr_cycle = ad;
		host_epp_sel = 1'b1;
		host_iow_n = !wr;
		host_ior_n = wr;
		for (k = 0; k < 300 && !(hit && !iochrdy_stretch); k++) begin
			tick();
			if (!hit && !(ad ? addr_strobe_n : data_strobe_n)) begin
				hit = 1'b1;
				w = write_n;
				pd = port_data_lines_out;
			end
		end
		hang(k, 300);
		chk(8'(timeout_flag), 8'(tmo));
		if (!tmo) begin
			chk(8'(w), 8'(!wr));
			chk(wr ? pd : system_data_bus_out, d);
		end
		host_iow_n = 1'b1;
		host_ior_n = 1'b1;
		host_epp_sel = 1'b0;
		repeat (8) tick();
		chk({2'h0, write_n, port_data_lines_oe_n, data_strobe_n, addr_strobe_n,
			iochrdy_stretch, system_data_bus_oe}, 8'h3c);
	endtask
	task automatic wait_got(input int n);
		int k;
		for (k = 0; k < 3000 && got.size() < n; k++) begin
			tick();
		end
		hang(k, 3000);
	endtask
	initial begin
		repeat (4) tick();
		sys_rst = 1'b0;
		tick();
		chk({write_n, port_data_lines_oe_n, data_strobe_n, addr_strobe_n, strobe_n,
			dma_ready, iochrdy_stretch, timeout_flag}, 8'hfc);
		// Every variant, direction and strobe kind, then random ones
		for (i = 0; i < 8; i++) begin
			epp_variant_17 = i[2];
			cyc(i[0], i[1], 1'b0);
		end
		repeat (12) begin
			r = rnd();
			mode = (r[2:0] == epp_pkg::MODE_FIFO) ? 3'h0 : r[2:0];
			epp_variant_17 = r[3];
			cyc(r[4], r[5], 1'b0);
		end
		// Peripheral never finishes, so the cycle must be abandoned
		epp_variant_17 = 1'b0;
		stall = 1'b1;
		cyc(1'b0, 1'b0, 1'b1);
		stall = 1'b0;
		timeout_clear = 1'b1;
		tick();
		timeout_clear = 1'b0;
		tick();
		chk(8'(timeout_flag), 8'h00);
		// Fill while busy holds off, then drain with a stall midway
		fstall = 1'b1;
		repeat (4) tick();
		mode = epp_pkg::MODE_FIFO;
		for (i = 0; i < 40 && dma_ready; i++) begin
			dma_data = rnd();
			dma_valid = 1'b1;
			@(posedge clk);
			q.push_back(dma_data);
			#2;
		end
		tick();
		dma_valid = 1'b0;
		chk(8'(q.size()), 8'(epp_pkg::FIFO_DEPTH));
		fstall = 1'b0;
		wait_got(5);
		fstall = 1'b1;
		repeat (30) tick();
		fstall = 1'b0;
		wait_got(16);
		foreach (q[j]) chk(got[j], q[j]);
		repeat (20) tick();
		chk(8'(got.size()), 8'h10);
		chk(port_data_lines_out, q[$]);
		chk({6'h00, port_data_lines_oe_n, dma_ready}, 8'h01);
		finish_test();
	end
endmodule // epp_cycle_sequencer_bench
`default_nettype wire

// ==== tb/epp_cycle_sequencer_chk.sv ====
/*
 Port assertions for the EPP cycle sequencer, attached by bind.
 Assumes one clock and a synchronous active-high reset.
*/
`default_nettype none
module epp_cycle_sequencer_chk (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [2:0] mode,
	input wire logic epp_variant_17,
	input wire logic host_iow_n,
	input wire logic wait_n,
	input wire logic busy,
	input wire logic write_n,
	input wire logic data_strobe_n,
	input wire logic addr_strobe_n,
	input wire logic strobe_n,
	input wire logic iochrdy_stretch,
	input wire logic timeout_flag,
	input wire logic system_data_bus_oe,
	input wire logic port_data_lines_oe_n,
	input wire logic [7:0] port_data_lines_out
);
	// Either strobe; raw wait is looked at two cycles back to cover the filter
	wire logic cmd_n = data_strobe_n & addr_strobe_n;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	a_write_low_cause: assert property (
		$fell(write_n) |-> iochrdy_stretch && !host_iow_n) else $error("stray write");
	a_read_hiz_first: assert property (
		$fell(cmd_n) && write_n && !epp_variant_17 |->
		port_data_lines_oe_n && $past(port_data_lines_oe_n)) else $error("data not released");
	a_strobe_after_wait: assert property (
		$fell(cmd_n) && !epp_variant_17 |-> !$past(wait_n, 2)) else $error("strobe before ready");
	a_strobe_hold_wait: assert property (
		$rose(cmd_n) && !epp_variant_17 && !timeout_flag |-> $past(wait_n, 2))
		else $error("early strobe end");
	a_stretch_end: assert property (
		$fell(iochrdy_stretch) |-> $past(wait_n, 2) || timeout_flag) else $error("early stretch end");
	a_read_data_first: assert property (
		$fell(iochrdy_stretch) && write_n && !timeout_flag |->
		system_data_bus_oe && $past(system_data_bus_oe)) else $error("read data late");
	a_fifo_pulse: assert property (
		$fell(strobe_n) |-> (!strobe_n && $stable(port_data_lines_out))[*6] ##1 strobe_n)
		else $error("fifo strobe width");
	a_fifo_busy: assert property (
		$changed(port_data_lines_out) && mode == epp_pkg::MODE_FIFO |-> !$past(busy, 3))
		else $error("byte while busy");
endmodule // epp_cycle_sequencer_chk
bind epp_cycle_sequencer epp_cycle_sequencer_chk u_chk (.*);
`default_nettype wire

// ==== tb/epp_peripheral_model.sv ====
/*
 Behavioural EPP and FIFO-mode peripheral for the sequencer bench.
 Assumes stall controls and read data come from the bench.
*/
`default_nettype none
module epp_peripheral_model (
	input wire logic clk,
	input wire logic epp_variant_17,
	input wire logic stall,
	input wire logic fstall,
	input wire logic [7:0] rd_val,
	input wire logic data_strobe_n,
	input wire logic addr_strobe_n,
	input wire logic strobe_n,
	input wire logic write_n,
	output logic wait_n,
	output logic busy,
	output logic [7:0] port_data_lines_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] n = 4'h0;
	logic [3:0] bm = 4'hf;
	wire logic cmd_n = data_strobe_n & addr_strobe_n;
	initial begin
		wait_n = 1'b0;
		busy = 1'b0;
		port_data_lines_in = 8'h00;
	end
	// Ready while idle, done 4 cycles into the strobe; 1.7 never holds off
	always @(posedge clk) begin
		n <= cmd_n ? 4'h0 : n + {3'h0, n != 4'hf};
		wait_n <= epp_variant_17 | (!cmd_n && n > 4'h2 && !stall);
		bm <= !strobe_n ? 4'h0 : bm + {3'h0, bm != 4'hf};
		busy <= fstall | !strobe_n | (bm < 4'h2);
		// Released lines scramble so a stale byte cannot pass
		port_data_lines_in <= (!cmd_n && write_n) ? rd_val : ~port_data_lines_in;
	end
endmodule // epp_peripheral_model
`default_nettype wire
